// [logic/scs_params.svh]
`ifndef SCS_PARAMS_SVH
`define SCS_PARAMS_SVH
// Summary of operation
// - Code 1,0 starts zero-scale step
// - Code 1,1 starts full-scale step
// - Step lasts three periods, mode clears
// - Ready high from start until new word
// - Extra conversion; ready low after four
// - Ready may rise up to 128 clocks
// - Host ignores ready one modulator cycle
// - Host runs zero step before full
// - Steps use currently selected gain
// - Unipolar ends or bipolar midscale points
// - Later single step updates own coefficient
// - Host keeps full-scale below 1.05 limit; host logic does not check it
// - Span between 0.8 and 2.1 limits
// - Reset loads nominal coefficients
// - Host calibrates after oscillator start-up
// - Separate zero and full coefficient registers
`define SCS_MODE_NORMAL     2'h0
`define SCS_MODE_ZERO       2'h2
`define SCS_MODE_FULL       2'h3
`define SCS_MOD_CYCLE       128
`define SCS_STEP_PERIODS    3
`define SCS_CONV_PERIODS    1
`define SCS_ZERO_COEF_RST   24'h000000
`define SCS_FULL_COEF_RST   24'h800000
`define SCS_DATA_RST        16'h0000
`define SCS_HOST_WAIT_CYC   128
`endif

// [logic/scs_pkg.sv]
package scs_pkg;
  typedef enum logic [1:0] {
    SCS_IDLE = 2'h0,
    SCS_SYNC = 2'h1,
    SCS_STEP = 2'h3,
    SCS_CONV = 2'h2
  } scs_state_t;
endpackage

// [logic/scs_link_if.sv]
`timescale 1ns/1ps
// Host-to-converter link: a completed mode write and the ready line back.
interface scs_link_if;
  logic [1:0]  calMode;
  logic        calWrite;
  logic [1:0]  calModeRead;
  logic        dataReady_n;
  logic [15:0] dataWord;
  modport device (input calMode, input calWrite, output calModeRead, output dataReady_n, output dataWord);
  modport host   (output calMode, output calWrite, input calModeRead, input dataReady_n, input dataWord);
endinterface

// [logic/scs_device.sv]
`timescale 1ns/1ps
`include "scs_params.svh"
module scs_device #(
  parameter int PERIOD_CYC = 1024,
  parameter int CW         = 24
) (
  input  wire logic          core_clk,
  input  wire logic          rst_n,
  scs_link_if.device         link,
  input  wire logic          bipolarMode,
  input  wire logic [2:0]    gainSel,
  input  wire logic [CW-1:0] modulatorSample,
  output logic [CW-1:0]      zeroCoef,
  output logic [CW-1:0]      fullCoef,
  output logic [2:0]         calGain,
  output logic               calBipolar,
  output logic               calBusy
);
  // ---------------------------------------------------------------
  // Sequencer state
  // ---------------------------------------------------------------
  scs_pkg::scs_state_t state_r, state_nxt;
  logic [15:0]   cnt_r;
  logic [1:0]    per_r;
  logic [1:0]    mode_r;
  logic          rdyN_r;
  logic [15:0]   data_r;
  logic [CW-1:0] zero_r, full_r;
  logic [2:0]    gain_r;
  logic          bip_r;
  logic [6:0]    mod_r;

  // ---------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------
  // A step starts only on a calibration code.
  wire startZero  = link.calWrite && link.calMode == `SCS_MODE_ZERO;
  wire startFull  = link.calWrite && link.calMode == `SCS_MODE_FULL;
  wire startCal   = startZero || startFull;
  wire periodEnd  = cnt_r == 16'(PERIOD_CYC - 1);
  wire modEdge    = mod_r == 7'(`SCS_MOD_CYCLE - 1);
  wire stepDone   = state_r == scs_pkg::SCS_STEP && periodEnd && per_r == 2'(`SCS_STEP_PERIODS - 1);
  wire convDone   = state_r == scs_pkg::SCS_CONV && periodEnd;
  // Normal conversions complete once per period while idle.
  wire idleWord   = state_r == scs_pkg::SCS_IDLE && periodEnd && !startCal;

  // Next-state selection; a new command restarts the sequence.
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      scs_pkg::SCS_IDLE: if (startCal) state_nxt = rdyN_r ? scs_pkg::SCS_STEP : scs_pkg::SCS_SYNC;
      scs_pkg::SCS_SYNC: if (modEdge) state_nxt = scs_pkg::SCS_STEP;
      scs_pkg::SCS_STEP: if (stepDone) state_nxt = scs_pkg::SCS_CONV;
      scs_pkg::SCS_CONV: if (convDone) state_nxt = scs_pkg::SCS_IDLE;
    endcase
    if (startCal && state_r != scs_pkg::SCS_IDLE) begin
      state_nxt = scs_pkg::SCS_STEP;
    end
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  // Modulator cycle divider runs freely.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) mod_r <= 7'h00;
    else        mod_r <= mod_r + 7'h01;
  end

  // Period counter, restarted by each command and held in sync, so step timing counts from the command or the sync edge.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= 16'h0000;
      per_r <= 2'h0;
    end else if (startCal || periodEnd || state_r == scs_pkg::SCS_SYNC) begin
      cnt_r <= 16'h0000;
      per_r <= (startCal || state_r != scs_pkg::SCS_STEP || stepDone) ? 2'h0 : per_r + 2'h1;
    end else begin
      cnt_r <= cnt_r + 16'h0001;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) state_r <= scs_pkg::SCS_IDLE;
    else        state_r <= state_nxt;
  end

  // Mode bits read back the running step and clear at its end.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n)        mode_r <= `SCS_MODE_NORMAL;
    else if (startCal) mode_r <= link.calMode;
    else if (stepDone) mode_r <= `SCS_MODE_NORMAL;
  end

  // Gain and polarity are frozen at the command for the whole step.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      gain_r <= 3'h0;
      bip_r  <= 1'b0;
    end else if (startCal) begin
      gain_r <= gainSel;
      bip_r  <= bipolarMode;
    end
  end

  // Each step writes only its own coefficient; reset loads nominal values.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      zero_r <= CW'(`SCS_ZERO_COEF_RST);
      full_r <= CW'(`SCS_FULL_COEF_RST);
    end else if (stepDone && mode_r == `SCS_MODE_ZERO) begin
      zero_r <= modulatorSample;
    end else if (stepDone && mode_r == `SCS_MODE_FULL) begin
      full_r <= modulatorSample;
    end
  end

  // Data word and ready line; no load while a step runs.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdyN_r <= 1'b1;
      data_r <= `SCS_DATA_RST;
    end else if (state_r == scs_pkg::SCS_SYNC && modEdge) begin
      rdyN_r <= 1'b1;
    end else if (startCal && rdyN_r) begin
      rdyN_r <= 1'b1;
    end else if (convDone || idleWord) begin
      rdyN_r <= 1'b0;
      data_r <= 16'(modulatorSample - zero_r);
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign link.calModeRead = mode_r;
  assign link.dataReady_n = rdyN_r;
  assign link.dataWord    = data_r;
  assign zeroCoef         = zero_r;
  assign fullCoef         = full_r;
  assign calGain          = gain_r;
  assign calBipolar       = bip_r;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) calBusy <= 1'b0;
    else        calBusy <= state_nxt == scs_pkg::SCS_STEP;
  end
endmodule

// [logic/scs_host.sv]
`timescale 1ns/1ps
`include "scs_params.svh"
module scs_host (
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  scs_link_if.host        link,
  input  wire logic       reqFull,
  input  wire logic       reqZero,
  input  wire logic       refStable,
  output logic            hostBusy,
  output logic            stepOk,
  output logic [15:0]     lastWord
);
  // ---------------------------------------------------------------
  // Host sequencing
  // ---------------------------------------------------------------
  logic [1:0] mode_r;
  logic       wr_r;
  logic       busy_r;
  logic       zeroDone_r;
  logic [7:0] wait_r;
  logic [15:0] word_r;

  // Full-scale alone is allowed only after a zero step; reference must be stable.
  wire canFull  = zeroDone_r;
  wire goZero   = !busy_r && reqZero && refStable;
  wire goFull   = !busy_r && !reqZero && reqFull && refStable && canFull;
  wire waitDone = wait_r == 8'h00;
  wire finished = busy_r && waitDone && !link.dataReady_n;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_r     <= `SCS_MODE_NORMAL;
      wr_r       <= 1'b0;
      busy_r     <= 1'b0;
      zeroDone_r <= 1'b0;
      wait_r     <= 8'h00;
      word_r     <= 16'h0000;
    end else begin
      wr_r <= goZero || goFull;
      if (goZero || goFull) begin
        mode_r <= goZero ? `SCS_MODE_ZERO : `SCS_MODE_FULL;
        busy_r <= 1'b1;
        wait_r <= 8'(`SCS_HOST_WAIT_CYC);
      end else if (wr_r) begin
        // Restart the guard once the write is on the link, so that it covers the device's sync delay.
        wait_r <= 8'(`SCS_HOST_WAIT_CYC);
      end else if (!waitDone) begin
        wait_r <= wait_r - 8'h01;
      end else if (finished) begin
        busy_r <= 1'b0;
        word_r <= link.dataWord;
        if (mode_r == `SCS_MODE_ZERO) zeroDone_r <= 1'b1;
      end
    end
  end

  assign link.calMode  = mode_r;
  assign link.calWrite = wr_r;
  assign hostBusy      = busy_r;
  assign lastWord      = word_r;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) stepOk <= 1'b0;
    else        stepOk <= finished;
  end
endmodule

// [verification/scs_chk.sv]
`timescale 1ns/1ps
module scs_chk #(
  parameter int PERIOD_CYC = 16
) (
  input wire logic        core_clk,
  input wire logic        rst_n,
  input wire logic [1:0]  calMode,
  input wire logic        calWrite,
  input wire logic [1:0]  calModeRead,
  input wire logic        dataReady_n,
  input wire logic [15:0] dataWord
);
  localparam int STEP_MIN = 3 * PERIOD_CYC - 12;
  localparam int STEP_MAX = 3 * PERIOD_CYC + 132;
  localparam int CONV_MAX = PERIOD_CYC + 4;
  // --------------------------------
  // Step and ready checks
  // --------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // A taken command, and a step that is still running.
  wire cmdTaken = calWrite && calMode[1];
  wire stepOn   = calModeRead != 2'h0;
  sequence stepRuns;
    stepOn [*8] ##[STEP_MIN:STEP_MAX] !stepOn;
  endsequence
  sequence convRuns;
    dataReady_n [*8] ##[1:CONV_MAX] !dataReady_n;
  endsequence
  chk_zero_start: assert property (cmdTaken && !calMode[0] |=> calModeRead == 2'h2)
    else $error("zero step code not shown");
  chk_full_start: assert property (cmdTaken && calMode[0] |=> calModeRead == 2'h3)
    else $error("full step code not shown");
  chk_mode_clear: assert property (cmdTaken |=> stepRuns)
    else $error("mode bits not cleared in time");
  chk_mode_hold: assert property (stepOn && !calWrite |=> !stepOn || $stable(calModeRead))
    else $error("mode bits changed mid step");
  chk_ready_rise: assert property (cmdTaken |-> ##[1:130] dataReady_n)
    else $error("ready not raised after command");
  chk_ready_conv: assert property ($fell(stepOn) |-> convRuns)
    else $error("ready not low one period after step");
  chk_word_frozen: assert property (stepOn |=> $stable(dataWord))
    else $error("data word loaded during step");
  chk_reset_state: assert property ($rose(rst_n) |-> dataReady_n && !stepOn)
    else $error("bad state after reset");
endmodule

// [verification/system_calibration_sequencer_tb.sv]
`timescale 1ns/1ps
module system_calibration_sequencer_tb;
  logic        core_clk, rst_n, bipolarMode, reqZero, reqFull, refStable;
  logic        calBusy, calBipolar, hostBusy, stepOk;
  logic [2:0]  gainSel, calGain;
  logic [23:0] sample, zeroCoef, fullCoef;
  logic [15:0] lastWord;
  int          n_errors, check_count, seed, k;
  scs_link_if  link ();
  scs_device #(.PERIOD_CYC(16)) scs_device_inst (.core_clk(core_clk), .rst_n(rst_n), .link(link),
    .bipolarMode(bipolarMode), .gainSel(gainSel), .modulatorSample(sample), .zeroCoef(zeroCoef),
    .fullCoef(fullCoef), .calGain(calGain), .calBipolar(calBipolar), .calBusy(calBusy));
  scs_host scs_host_inst (.core_clk(core_clk), .rst_n(rst_n), .link(link), .reqFull(reqFull),
    .reqZero(reqZero), .refStable(refStable), .hostBusy(hostBusy), .stepOk(stepOk), .lastWord(lastWord));
  scs_chk #(.PERIOD_CYC(16)) scs_chk_inst (.core_clk(core_clk), .rst_n(rst_n), .calMode(link.calMode),
    .calWrite(link.calWrite), .calModeRead(link.calModeRead), .dataReady_n(link.dataReady_n),
    .dataWord(link.dataWord));
  // Clock of 100 ns period.
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  // Expected word: sample less the zero coefficient.
  function automatic logic [15:0] expWord(logic [23:0] s, logic [23:0] z);
    return 16'(s - z);
  endfunction
  // Counts one comparison and reports a mismatch.
  task automatic check(string what, logic [23:0] exp, logic [23:0] got);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %s exp %h got %h", what, exp, got);
    end
  endtask
  task automatic test_done();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Runs one step with a fresh stable input and random gain and polarity.
  task automatic run_step(input logic full);
    logic [23:0] z, f;
    int          i;
    z = zeroCoef;
    f = fullCoef;
    @(posedge core_clk);
    refStable <= 1'b0;
    gainSel <= 3'($random(seed));
    bipolarMode <= 1'($random(seed));
    // Full-scale input sits a bounded span above the zero point.
    sample <= full ? z + 24'h400000 + 24'($random(seed) & 32'h3fffff) : 24'($random(seed) & 32'h3fffff);
    @(posedge core_clk);
    refStable <= 1'b1;
    reqFull <= full;
    reqZero <= !full;
    repeat (2) @(posedge core_clk);
    reqFull <= 1'b0;
    reqZero <= 1'b0;
    for (i = 0; i < 500 && stepOk !== 1'b1; i++) begin
      @(posedge core_clk);
      #1;
    end
    if (i == 500) begin
      n_errors++;
      test_done();
    end
    check("calModeRead", 24'h0, 24'(link.calModeRead));
    check("calGain", 24'(gainSel), 24'(calGain));
    check("calBipolar", 24'(bipolarMode), 24'(calBipolar));
    check("other coef", full ? z : f, full ? zeroCoef : fullCoef);
    if (!full) check("zeroCoef", sample, zeroCoef);
    if (full) check("fullCoef", sample, fullCoef);
    check("lastWord", 24'(expWord(sample, full ? z : sample)), 24'(lastWord));
    check("hostBusy", 24'h0, 24'(hostBusy));
    check("calBusy", 24'h0, 24'(calBusy));
    $display("step full=%0d done", full);
  endtask
  // Reset, defaults, then five steps back to back, alternating zero and full, starting with zero.
  initial begin
    seed = 32'hee27;
    n_errors = 0;
    check_count = 0;
    rst_n = 1'b0;
    reqZero = 1'b0;
    reqFull = 1'b0;
    refStable = 1'b0;
    bipolarMode = 1'b0;
    gainSel = 3'h0;
    sample = 24'h0;
    repeat (6) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    #1;
    check("zeroCoef", 24'h0, zeroCoef);
    check("fullCoef", 24'h800000, fullCoef);
    for (k = 0; k < 5; k++) run_step(k[0]);
    test_done();
  end
endmodule
